// ---- rtl/csi_pkg.sv ----
/*
  Shared constants and types for the charger status and interrupt logic.
  Assumes a single 100 MHz clock and a one-cycle register port.
*/
`default_nettype none
package csi_pkg;
   // Register port widths.
   localparam int unsigned AW = 4;
   localparam int unsigned DW = 8;
   // Register addresses.
   localparam logic [3:0] A_STATUS   = 4'h0;
   localparam logic [3:0] A_EV_BASE  = 4'h1;
   localparam logic [3:0] A_MSK_BASE = 4'h5;
   localparam logic [3:0] A_CTL_ONE  = 4'h9;
   localparam logic [3:0] A_CTL_TWO  = 4'hA;
   localparam logic [3:0] A_SNS_IN   = 4'hB;
   localparam logic [3:0] A_SNS_BAT  = 4'hC;
   localparam logic [3:0] A_SNS_TMP  = 4'hD;
   // Event register indices within the event and mask banks.
   localparam int unsigned R_STATE = 0;
   localparam int unsigned R_CHA   = 1;
   localparam int unsigned R_CHB   = 2;
   localparam int unsigned R_BST   = 3;
   // Event bit positions.
   localparam int unsigned E_STATE = 0;
   localparam int unsigned E_COLD  = 0;
   localparam int unsigned E_HOT   = 1;
   localparam int unsigned E_BATRM = 2;
   localparam int unsigned E_TRANS = 0;
   localparam int unsigned E_ILIM  = 0;
   localparam int unsigned E_OV    = 1;
   // Control bit positions and reset values.
   localparam int unsigned C1_PMSK  = 0;
   localparam int unsigned C1_IMSK  = 1;
   localparam int unsigned C1_NTCEN = 2;
   localparam int unsigned C1_OTG   = 3;
   localparam int unsigned C2_TRANS = 0;
   localparam int unsigned C2_FACT  = 1;
   localparam logic [7:0] CTL_ONE_RST = 8'h04;
   localparam logic [7:0] CTL_TWO_RST = 8'h01;
   // Charge and boost state codes.
   localparam logic [3:0] ST_OFF = 4'h0, ST_WAIT = 4'h1, ST_SAFE = 4'h2;
   localparam logic [3:0] ST_PRE = 4'h3, ST_FULL = 4'h4, ST_VOLT = 4'h5;
   localparam logic [3:0] ST_DONE = 4'h6, ST_DPP = 4'h7, ST_WWAIT = 4'h8;
   localparam logic [3:0] ST_WSAFE = 4'h9, ST_WCHG = 4'hA;
   localparam logic [3:0] ST_FAULT = 4'hB, ST_BWAIT = 4'hC;
   localparam logic [3:0] ST_BON = 4'hD, ST_BOL = 4'hF;
   // Boost start-up window.
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BOOST_START_NS = 16000000;
   localparam int unsigned BOOST_START_CYC = BOOST_START_NS / CLK_PERIOD_NS;
   // Comparator and pin inputs, all asynchronous to clk.
   typedef struct packed {
      logic otg_pin;      // Boost request pin.
      logic ntc_det;      // Thermistor presence probe.
      logic batfet_det;   // Battery switch presence probe.
      logic bat_low;      // Battery below its low threshold.
      logic vin_boost_ok; // Input pin above the boost start level.
      logic vin_ov;       // Input above the over-voltage limit.
      logic vin_valid;    // Input above the under-voltage limit.
      logic ntc_gnd;      // Thermistor pin tied to ground.
      logic ntc_rmv;      // Thermistor removed.
      logic ntc_hot;      // Beyond the hot threshold.
      logic ntc_cold;     // Beyond the cold threshold.
   } csi_cmp_t;
   localparam int unsigned CMP_W = $bits(csi_cmp_t);
   // Boost supervisor states.
   typedef enum logic [3:0] {
      B_IDLE  = 4'b0001,
      B_START = 4'b0010,
      B_ON    = 4'b0100,
      B_LOCK  = 4'b1000
   } csi_bst_t;
endpackage
`default_nettype wire

// ---- rtl/csi_status_irq.sv ----
/*
  Charger status pin, interrupt pin, event registers and boost supervisor.
  Assumes comparator inputs are asynchronous and that the charge state
  code and configuration phase come from logic on the same clock.
*/
// Function
// - Temperature crossing interrupts; halt outside window
// - Thermistor removal stops charge, interrupts, enable bit
// - Grounded thermistor disables temperature monitoring
// - Transceiver supply only on valid input, maskable
// - Status pin low when active or waiting
// - Fixed-width status pulse for every event outside a pulse
// - Simultaneous events give one pulse only
// - Pulse polarity opposite the resting level
// - Global bit suppresses all status pulses
// - Interrupt pin low per unmasked event
// - Event bits set on edge, clear on read
// - Interrupt pin low while any unmasked bit pending
// - State field live, change raises event
// - Presence probed in config, shown from wait
// - Summary bits nonzero while events pending
// - Sense registers show live comparator levels
// - Charge decisions use debounced comparator signals
// - Battery removal forces fault, sets removal bit
// - After removal settle weak-wait only with switch
// - Factory bit disables current limiting loops
// - Boost start timeout sets limit fault, stops
// - Boost over-voltage stops, clears request bit
// - Four-bit state codes as listed
`default_nettype none
module csi_status_irq #(
   parameter int unsigned DEB_CYC   = 16,
   parameter int unsigned PULSE_CYC = 100,
   parameter int unsigned BOOST_CYC = csi_pkg::BOOST_START_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   ce,
   input  wire logic [csi_pkg::AW-1:0] addr,
   input  wire logic [csi_pkg::DW-1:0] wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output var  logic [csi_pkg::DW-1:0] rdata,
   input  wire csi_pkg::csi_cmp_t      cmp_in,
   input  wire logic [3:0]             charge_state,
   input  wire logic                   cfg_phase,
   output var  csi_pkg::csi_cmp_t      cmp_deb,
   output var  logic                   flag_pin,
   output var  logic                   irq_pin_n,
   output var  logic                   charge_halt,
   output var  logic                   removal_fault,
   output var  logic                   settle_weak_wait,
   output var  logic                   trans_en,
   output var  logic                   loops_disable,
   output var  logic                   boost_run
);
   // Synchroniser stages; only the second stage feeds logic.
   logic [csi_pkg::CMP_W-1:0] sy1, sy2;
   // Debounced comparators and their previous value.
   logic [csi_pkg::CMP_W-1:0] deb, deb_q;
   csi_pkg::csi_cmp_t cs, cd, cq;

   // Two-flop synchroniser for every asynchronous input.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sy1 <= '0;
         sy2 <= '0;
      end else if (ce) begin
         sy1 <= cmp_in;
         sy2 <= sy1;
      end
   end

   // Each input must hold a new level for DEB_CYC cycles to pass.
   genvar g;
   generate
      for (g = 0; g < csi_pkg::CMP_W; g++) begin : g_deb
         logic [15:0] cnt, next_cnt;
         logic        next_deb;
         // Count while the synced level differs from the filtered one.
         always_comb begin
            next_cnt = '0;
            next_deb = deb[g];
            if (sy2[g] != deb[g]) begin
               next_cnt = cnt + 16'h0001;
               if (cnt == 16'(DEB_CYC - 1)) begin
                  next_deb = sy2[g];
                  next_cnt = '0;
               end
            end
         end
         // Filter state.
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt    <= '0;
               deb[g] <= 1'b0;
            end else if (ce) begin
               cnt    <= next_cnt;
               deb[g] <= next_deb;
            end
         end
      end
   endgenerate

   assign cs = sy2;
   assign cd = deb;
   assign cq = deb_q;

   // True while the state is charger-active or wait.
   function automatic logic rest_low(input logic [3:0] s);
      rest_low = (s == csi_pkg::ST_WAIT) || (s == csi_pkg::ST_SAFE) ||
                 (s == csi_pkg::ST_PRE) || (s == csi_pkg::ST_FULL) ||
                 (s == csi_pkg::ST_VOLT) || (s == csi_pkg::ST_WSAFE) ||
                 (s == csi_pkg::ST_WCHG);
   endfunction

   // Event, mask and control storage.
   logic [3:0][7:0] ev, next_ev, msk, next_msk, set;
   logic [7:0]      ctl_one, next_ctl_one, ctl_two, next_ctl_two;
   logic [7:0]      next_rdata;
   logic [3:0]      state_q;
   logic            bfet, ntcp, next_bfet, next_ntcp;
   logic            mon, outside, unmasked;
   // Boost supervisor outputs.
   logic            otg_clr, ilim_ev, ov_ev;

   // Event sources and read-clear with set taking priority.
   always_comb begin
      mon = !cd.ntc_gnd;
      outside = cd.ntc_cold || cd.ntc_hot;
      set = '0;
      set[csi_pkg::R_STATE][csi_pkg::E_STATE] =
         (charge_state != state_q);
      set[csi_pkg::R_CHA][csi_pkg::E_COLD] =
         mon && (cd.ntc_cold != cq.ntc_cold);
      set[csi_pkg::R_CHA][csi_pkg::E_HOT] =
         mon && (cd.ntc_hot != cq.ntc_hot);
      set[csi_pkg::R_CHA][csi_pkg::E_BATRM] = mon &&
         ctl_one[csi_pkg::C1_NTCEN] && cd.ntc_rmv && !cq.ntc_rmv;
      set[csi_pkg::R_CHB][csi_pkg::E_TRANS] =
         (cd.vin_valid != cq.vin_valid);
      set[csi_pkg::R_BST][csi_pkg::E_ILIM] = ilim_ev;
      set[csi_pkg::R_BST][csi_pkg::E_OV] = ov_ev;
      next_ev = ev;
      next_msk = msk;
      next_ctl_one = ctl_one;
      next_ctl_two = ctl_two;
      for (int i = 0; i < 4; i++) begin
         if (rd && addr == csi_pkg::A_EV_BASE + 4'(i)) begin
            next_ev[i] = '0;
         end
         next_ev[i] = next_ev[i] | set[i];
         if (wr && addr == csi_pkg::A_MSK_BASE + 4'(i)) begin
            next_msk[i] = wdata;
         end
      end
      if (wr && addr == csi_pkg::A_CTL_ONE) begin
         next_ctl_one = wdata;
      end
      if (wr && addr == csi_pkg::A_CTL_TWO) begin
         next_ctl_two = wdata;
      end
      // Over-voltage drops the boost request even against a write.
      if (otg_clr) begin
         next_ctl_one[csi_pkg::C1_OTG] = 1'b0;
      end
      // Presence probes are caught only during configuration.
      next_bfet = cfg_phase ? cd.batfet_det : bfet;
      next_ntcp = cfg_phase ? cd.ntc_det : ntcp;
      unmasked = |(ev & ~msk) && !ctl_one[csi_pkg::C1_IMSK];
      // Read data, registered for the following cycle.
      next_rdata = '0;
      if (rd) begin
         unique case (addr)
            csi_pkg::A_STATUS: next_rdata = {state_q,
               bfet && state_q != csi_pkg::ST_OFF,
               ntcp && state_q != csi_pkg::ST_OFF,
               |ev[csi_pkg::R_STATE],
               |ev[csi_pkg::R_BST:csi_pkg::R_CHA]};
            csi_pkg::A_CTL_ONE: next_rdata = ctl_one;
            csi_pkg::A_CTL_TWO: next_rdata = ctl_two;
            csi_pkg::A_SNS_IN: next_rdata =
               {5'h00, cs.vin_boost_ok, cs.vin_ov, cs.vin_valid};
            csi_pkg::A_SNS_BAT: next_rdata = {7'h00, cs.bat_low};
            csi_pkg::A_SNS_TMP: next_rdata = {4'h0, cs.ntc_gnd,
               cs.ntc_rmv, cs.ntc_hot, cs.ntc_cold};
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (addr == csi_pkg::A_EV_BASE + 4'(i)) begin
                     next_rdata = ev[i];
                  end
                  if (addr == csi_pkg::A_MSK_BASE + 4'(i)) begin
                     next_rdata = msk[i];
                  end
               end
            end
         endcase
      end
   end

   // Register storage and the pins derived from it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ev <= '0;
         msk <= '0;
         ctl_one <= csi_pkg::CTL_ONE_RST;
         ctl_two <= csi_pkg::CTL_TWO_RST;
         rdata <= '0;
         state_q <= csi_pkg::ST_OFF;
         deb_q <= '0;
         bfet <= 1'b0;
         ntcp <= 1'b0;
         irq_pin_n <= 1'b1;
         charge_halt <= 1'b0;
         removal_fault <= 1'b0;
         settle_weak_wait <= 1'b0;
         trans_en <= 1'b0;
         loops_disable <= 1'b0;
         cmp_deb <= '0;
      end else if (ce) begin
         ev <= next_ev;
         msk <= next_msk;
         ctl_one <= next_ctl_one;
         ctl_two <= next_ctl_two;
         rdata <= next_rdata;
         state_q <= charge_state;
         deb_q <= deb;
         bfet <= next_bfet;
         ntcp <= next_ntcp;
         irq_pin_n <= !unmasked;
         charge_halt <= mon && (outside ||
            (ctl_one[csi_pkg::C1_NTCEN] && cd.ntc_rmv));
         removal_fault <= set[csi_pkg::R_CHA][csi_pkg::E_BATRM];
         settle_weak_wait <= bfet;
         trans_en <= cd.vin_valid && !cd.vin_ov &&
            ctl_two[csi_pkg::C2_TRANS];
         loops_disable <= ctl_two[csi_pkg::C2_FACT];
         cmp_deb <= deb;
      end
   end

   // Status pulse timer.
   logic [15:0] pcnt, next_pcnt;
   logic        new_ev;

   // One pulse per batch of events; restarts are ignored mid-pulse.
   always_comb begin
      new_ev = |set && !ctl_one[csi_pkg::C1_PMSK];
      next_pcnt = pcnt;
      if (pcnt != '0) begin
         next_pcnt = pcnt - 16'h0001;
      end else if (new_ev) begin
         next_pcnt = 16'(PULSE_CYC);
      end
   end

   // Pulse counter and the status pin.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pcnt <= '0;
         flag_pin <= 1'b1;
      end else if (ce) begin
         pcnt <= next_pcnt;
         flag_pin <= rest_low(charge_state) ^
            !(next_pcnt != '0);
      end
   end

   // Boost supervisor.
   csi_pkg::csi_bst_t bst, next_bst;
   logic [31:0]       bcnt, next_bcnt;
   logic              breq;

   // Start on pin or bit, time the start-up, trip on over-voltage.
   always_comb begin
      breq = cs.otg_pin || ctl_one[csi_pkg::C1_OTG];
      next_bst = bst;
      next_bcnt = '0;
      otg_clr = 1'b0;
      ilim_ev = 1'b0;
      ov_ev = 1'b0;
      unique case (bst)
         csi_pkg::B_IDLE: if (breq) next_bst = csi_pkg::B_START;
         csi_pkg::B_START: begin
            next_bcnt = bcnt + 32'h1;
            if (cs.vin_ov) begin
               ov_ev = 1'b1;
               otg_clr = 1'b1;
               next_bst = csi_pkg::B_LOCK;
            end else if (!breq) begin
               next_bst = csi_pkg::B_IDLE;
            end else if (cs.vin_boost_ok) begin
               next_bst = csi_pkg::B_ON;
            end else if (bcnt == 32'(BOOST_CYC - 1)) begin
               ilim_ev = 1'b1;
               next_bst = csi_pkg::B_LOCK;
            end
         end
         csi_pkg::B_ON: begin
            if (cs.vin_ov) begin
               ov_ev = 1'b1;
               otg_clr = 1'b1;
               next_bst = csi_pkg::B_LOCK;
            end else if (!breq) begin
               next_bst = csi_pkg::B_IDLE;
            end
         end
         csi_pkg::B_LOCK: if (!breq) next_bst = csi_pkg::B_IDLE;
      endcase
   end

   // Boost state and run output.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bst <= csi_pkg::B_IDLE;
         bcnt <= '0;
         boost_run <= 1'b0;
      end else if (ce) begin
         bst <= next_bst;
         bcnt <= next_bcnt;
         boost_run <= (next_bst == csi_pkg::B_START) ||
            (next_bst == csi_pkg::B_ON);
      end
   end

   // Checks on the behaviour above.
   sequence s_pulse_hold;
      (pcnt != '0) [*2];
   endsequence
   property p_irq;
      @(posedge clk) disable iff (!arst_n)
         ce && unmasked |=> !irq_pin_n;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt pin not low with event pending.");
   property p_irq_mask;
      @(posedge clk) disable iff (!arst_n)
         ce && ctl_one[csi_pkg::C1_IMSK] |=> irq_pin_n;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("Global interrupt mask ignored.");
   property p_rc;
      @(posedge clk) disable iff (!arst_n)
         ce && rd && addr == csi_pkg::A_EV_BASE && !(|set[0])
         |=> ev[0] == '0;
   endproperty
   a_rc: assert property (p_rc)
      else $error("Event register not cleared by read.");
   property p_setwin;
      @(posedge clk) disable iff (!arst_n)
         ce && set[csi_pkg::R_BST][csi_pkg::E_OV]
         |=> ev[csi_pkg::R_BST][csi_pkg::E_OV];
   endproperty
   a_setwin: assert property (p_setwin)
      else $error("Event lost during read clear.");
   property p_state;
      @(posedge clk) disable iff (!arst_n)
         ce && charge_state != state_q
         |=> ev[csi_pkg::R_STATE][csi_pkg::E_STATE];
   endproperty
   a_state: assert property (p_state)
      else $error("State change raised no event.");
   property p_pulse;
      @(posedge clk) disable iff (!arst_n)
         ce && pcnt == '0 && new_ev ##1 ce |-> s_pulse_hold;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("Status pulse cut short.");
   property p_pmask;
      @(posedge clk) disable iff (!arst_n)
         ce && ctl_one[csi_pkg::C1_PMSK] && pcnt == '0 |=> pcnt == '0;
   endproperty
   a_pmask: assert property (p_pmask)
      else $error("Status pulse not masked.");
   property p_halt;
      @(posedge clk) disable iff (!arst_n)
         ce && mon && outside |=> charge_halt;
   endproperty
   a_halt: assert property (p_halt)
      else $error("Charge not halted outside window.");
   property p_ov;
      @(posedge clk) disable iff (!arst_n)
         ce && bst == csi_pkg::B_ON && cs.vin_ov
         |=> !ctl_one[csi_pkg::C1_OTG] && !boost_run;
   endproperty
   a_ov: assert property (p_ov)
      else $error("Over-voltage did not stop boost.");
endmodule
`default_nettype wire

// ---- sim/csi_host_model.sv ----
/*
  Processor-side model that watches the status pin; its interrupt pin input is unused.
  Assumes it shares the block's clock and reset.
*/
`default_nettype none
module csi_host_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       flag_pin,
   input  wire logic       irq_pin_n,
   output var  logic [7:0] edge_cnt,
   output var  logic [7:0] last_run
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       flag_q; // Status pin level one cycle back.
   logic [7:0] run;    // Cycles since the last status pin edge.
   // Counts status pin edges and keeps the length of the last run.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q   <= 1'b1;
         run      <= 8'h00;
         edge_cnt <= 8'h00;
         last_run <= 8'h00;
      end else if (flag_pin !== flag_q) begin
         flag_q   <= flag_pin;
         edge_cnt <= edge_cnt + 8'h01;
         last_run <= run + 8'h01;
         run      <= 8'h00;
      end else begin
         run <= run + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- sim/charger_status_interrupt_logic_tb_top.sv ----
/*
  Self-checking bench for the charger status and interrupt block.
  Assumes one 100 MHz clock and shortened debounce, pulse and boost counts.
*/
`default_nettype none
module charger_status_interrupt_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned PW = 4; // Shortened status pulse count.
   logic              clk, arst_n, ce, wr, rd, cfg_phase;
   logic              rf_seen = 1'b0; // Removal pulse seen once.
   logic [3:0]        addr, charge_state;
   logic [7:0]        wdata, rdata, edge_cnt, last_run, e0, d, r;
   csi_pkg::csi_cmp_t cmp_in, cmp_deb;
   logic              flag_pin, irq_pin_n, charge_halt, removal_fault;
   logic              settle_weak_wait, trans_en, loops_disable, boost_run;
   int                err_count, n_compared;

   csi_status_irq #(.DEB_CYC(2), .PULSE_CYC(PW), .BOOST_CYC(20)) dut_u (
      .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cmp_in(cmp_in),
      .charge_state(charge_state), .cfg_phase(cfg_phase),
      .cmp_deb(cmp_deb), .flag_pin(flag_pin), .irq_pin_n(irq_pin_n),
      .charge_halt(charge_halt), .removal_fault(removal_fault),
      .settle_weak_wait(settle_weak_wait), .trans_en(trans_en),
      .loops_disable(loops_disable), .boost_run(boost_run));

   csi_host_model host_u (
      .clk(clk), .arst_n(arst_n), .flag_pin(flag_pin),
      .irq_pin_n(irq_pin_n), .edge_cnt(edge_cnt), .last_run(last_run));

   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Catches the one-cycle removal pulse.
   always @(posedge clk) if (removal_fault === 1'b1) rf_seen <= 1'b1;

   // Resting status pin level for a state code.
   function automatic logic rest(input logic [3:0] s);
      case (s)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hA: rest = 1'b0;
         default: rest = 1'b1;
      endcase
   endfunction

   // Reset value of a register that reads back plainly.
   function automatic logic [7:0] rst_val(input logic [3:0] a);
      rst_val = (a == csi_pkg::A_CTL_ONE) ? csi_pkg::CTL_ONE_RST :
                (a == csi_pkg::A_CTL_TWO) ? csi_pkg::CTL_TWO_RST : 8'h00;
   endfunction

   // Counts and reports one comparison.
   task automatic chk(input string nm, input logic [7:0] ex,
                      input logic [7:0] got);
      n_compared++;
      if (got !== ex) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      // Read data stand for the one cycle after the strobe.
      @(posedge clk);
      v = rdata;
   endtask

   // Reads and clears all four event registers.
   task automatic clr_ev;
      for (int a = 1; a < 5; a++) rd_reg(4'(a), d);
   endtask

   // Waits out an event, checks pulse count, width and resting level.
   task automatic pulse(input logic [7:0] n);
      cyc(14);
      chk("flag_edges", n, edge_cnt - e0);
      if (n != 8'h00) chk("flag_width", 8'(PW), last_run);
      chk("flag_rest", {7'h00, rest(charge_state)}, {7'h00, flag_pin});
   endtask

   task automatic summarize;
      if (err_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog far beyond the expected run length.
   initial begin
      #200000;
      err_count++;
      summarize();
   end

   // Main sequence.
   initial begin
      {arst_n, wr, rd, cfg_phase} = 4'h0;
      ce = 1'b1;
      {addr, charge_state, wdata} = 16'h0000;
      cmp_in = '0;
      err_count = 0;
      n_compared = 0;
      void'($urandom(83));
      cyc(12);
      chk("flag_rst", 8'h01, {7'h00, flag_pin});
      chk("irq_rst", 8'h01, {7'h00, irq_pin_n});
      arst_n <= 1'b1;
      wr_reg(csi_pkg::A_SNS_IN, 8'hFF);
      wr_reg(4'hE, 8'hFF);
      for (int a = 5; a < 16; a++) begin
         rd_reg(4'(a), d);
         chk("reset_val", rst_val(4'(a)), d);
      end
      cmp_in.batfet_det <= 1'b1;
      cmp_in.ntc_det    <= 1'b1;
      cfg_phase         <= 1'b1;
      cyc(10);
      cfg_phase    <= 1'b0;
      charge_state <= csi_pkg::ST_WAIT;
      cyc(10);
      chk("weak_wait", 8'h01, {7'h00, settle_weak_wait});
      chk("irq_state", 8'h00, {7'h00, irq_pin_n});
      rd_reg(csi_pkg::A_STATUS, d);
      chk("status", 8'h1E, d);
      rd_reg(csi_pkg::A_EV_BASE, d);
      chk("ev_state", 8'h01, d);
      rd_reg(csi_pkg::A_EV_BASE, d);
      chk("ev_clear", 8'h00, d);
      cyc(2);
      chk("irq_clear", 8'h01, {7'h00, irq_pin_n});
      charge_state <= csi_pkg::ST_SAFE;
      cyc(14);
      clr_ev();
      e0 = edge_cnt;
      cmp_in.ntc_cold <= 1'b1;
      pulse(8'h02);
      chk("halt_cold", 8'h01, {7'h00, charge_halt});
      rd_reg(4'h2, d);
      chk("ev_cold", 8'h01, d);
      cmp_in.ntc_cold <= 1'b0;
      cyc(14);
      clr_ev();
      e0 = edge_cnt;
      cmp_in.ntc_hot <= 1'b1;
      cmp_in.ntc_rmv <= 1'b1;
      pulse(8'h02);
      chk("halt_rmv", 8'h01, {7'h00, charge_halt});
      chk("rmv_fault", 8'h01, {7'h00, rf_seen});
      chk("irq_multi", 8'h00, {7'h00, irq_pin_n});
      rd_reg(csi_pkg::A_STATUS, d);
      chk("status_fault", 8'h2D, d);
      rd_reg(4'h2, d);
      chk("ev_multi", 8'h06, d);
      charge_state <= csi_pkg::ST_DONE;
      cmp_in.ntc_hot <= 1'b0;
      cmp_in.ntc_rmv <= 1'b0;
      cyc(14);
      clr_ev();
      e0 = edge_cnt;
      cmp_in.ntc_cold <= 1'b1;
      pulse(8'h02);
      clr_ev();
      wr_reg(csi_pkg::A_CTL_ONE, 8'h05);
      e0 = edge_cnt;
      cmp_in.ntc_hot <= 1'b1;
      pulse(8'h00);
      chk("irq_nopulse", 8'h00, {7'h00, irq_pin_n});
      {cmp_in.ntc_hot, cmp_in.ntc_cold} <= 2'b00;
      wr_reg(csi_pkg::A_MSK_BASE + 4'h1, 8'h02);
      cyc(14);
      clr_ev();
      cmp_in.ntc_hot <= 1'b1;
      cyc(14);
      chk("irq_masked", 8'h01, {7'h00, irq_pin_n});
      rd_reg(4'h2, d);
      chk("ev_masked", 8'h02, d);
      wr_reg(csi_pkg::A_MSK_BASE + 4'h1, 8'h00);
      wr_reg(csi_pkg::A_CTL_ONE, 8'h07);
      cmp_in.ntc_cold <= 1'b1;
      cyc(14);
      chk("irq_global", 8'h01, {7'h00, irq_pin_n});
      wr_reg(csi_pkg::A_CTL_ONE, 8'h04);
      cmp_in.ntc_gnd <= 1'b1;
      {cmp_in.ntc_hot, cmp_in.ntc_cold} <= 2'b00;
      cyc(14);
      clr_ev();
      cmp_in.ntc_cold <= 1'b1;
      cyc(14);
      chk("gnd_halt", 8'h00, {7'h00, charge_halt});
      rd_reg(4'h2, d);
      chk("gnd_ev", 8'h00, d);
      for (int i = 0; i < 8; i++) begin
         r = 8'($urandom());
         {cmp_in.bat_low, cmp_in.vin_boost_ok, cmp_in.vin_ov} <= r[7:5];
         {cmp_in.vin_valid, cmp_in.ntc_gnd, cmp_in.ntc_rmv} <= r[4:2];
         {cmp_in.ntc_hot, cmp_in.ntc_cold} <= r[1:0];
         cyc(4);
         rd_reg(csi_pkg::A_SNS_IN, d);
         chk("sns_in", {5'h00, r[6:4]}, d);
         rd_reg(csi_pkg::A_SNS_BAT, d);
         chk("sns_bat", {7'h00, r[7]}, d);
         rd_reg(csi_pkg::A_SNS_TMP, d);
         chk("sns_tmp", {4'h0, r[3:0]}, d);
      end
      cmp_in <= '{vin_valid: 1'b1, default: 1'b0};
      cyc(14);
      clr_ev();
      chk("trans_on", 8'h01, {7'h00, trans_en});
      // A one-cycle glitch must not reach the debounced copy.
      cmp_in.bat_low <= 1'b1;
      @(posedge clk);
      cmp_in.bat_low <= 1'b0;
      cyc(6);
      chk("deb_glitch", 8'h10, cmp_deb[7:0]);
      chk("deb_upper", 8'h00, {5'h00, cmp_deb[10:8]});
      // A write while the clock enable is low must be ignored.
      ce <= 1'b0;
      wr_reg(csi_pkg::A_CTL_TWO, 8'h00);
      ce <= 1'b1;
      cyc(3);
      chk("ce_hold", 8'h01, {7'h00, trans_en});
      wr_reg(csi_pkg::A_CTL_TWO, 8'h00);
      cyc(3);
      chk("trans_off", 8'h00, {7'h00, trans_en});
      wr_reg(csi_pkg::A_CTL_TWO, 8'h03);
      cyc(3);
      chk("factory", 8'h01, {7'h00, loops_disable});
      wr_reg(csi_pkg::A_CTL_ONE, 8'h0C);
      cyc(40);
      chk("bst_tmo", 8'h00, {7'h00, boost_run});
      rd_reg(4'h4, d);
      chk("ev_ilim", 8'h01, d);
      wr_reg(csi_pkg::A_CTL_ONE, 8'h04);
      cmp_in.vin_boost_ok <= 1'b1;
      cyc(14);
      wr_reg(csi_pkg::A_CTL_ONE, 8'h0C);
      cyc(14);
      chk("bst_on", 8'h01, {7'h00, boost_run});
      clr_ev();
      cmp_in.vin_ov <= 1'b1;
      cyc(14);
      chk("bst_ov", 8'h00, {7'h00, boost_run});
      rd_reg(csi_pkg::A_CTL_ONE, d);
      chk("otg_clr", 8'h04, d);
      rd_reg(4'h4, d);
      chk("ev_ov", 8'h02, d);
      summarize();
   end
endmodule
`default_nettype wire
